// File: core/scd_pkg.sv
package scd_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] OFF_RUN_CFG = 8'h00;
    localparam logic [7:0] OFF_RUN_CFG_EXT = 8'h04;
    localparam logic [7:0] OFF_MAIN_OSCILLATOR_CTL = 8'h08;
    localparam logic [7:0] OFF_RESET_CAUSE = 8'h0C;
    localparam logic [7:0] OFF_CLK_GATE = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam int F_MAIN_OSCILLATOR_DIS = 0;
    localparam int F_INTERNAL_FAST_OSCILLATOR_DIS = 1;
    localparam int F_OSC_SEL = 4;
    localparam int F_SKIP = 11;
    localparam int F_PLL_PD = 13;
    localparam int F_PWM_DIV = 17;
    localparam int F_PWM_USE = 20;
    localparam int F_USE_DIV = 22;
    localparam int F_DIV = 23;
    localparam int F_X_OSC_SEL = 4;
    localparam int F_X_SKIP = 11;
    localparam int F_X_PLL_PD = 13;
    localparam int F_X_DIV = 23;
    localparam int F_X_USE = 31;
    localparam int F_CHECK_EN = 0;
    localparam int F_POR_FLAG = 0;
    localparam int F_FAIL_FLAG = 16;
    localparam logic [31:0] RUN_CFG_RST = 32'h078E2811;
    localparam logic [31:0] RUN_CFG_MASK = 32'h07DE2833;
    localparam logic [31:0] EXT_CFG_RST = 32'h0F802810;
    localparam logic [31:0] EXT_CFG_MASK = 32'h9F802870;
    localparam logic [31:0] MAIN_OSCILLATOR_CTL_MASK = 32'h00000001;
    localparam logic [31:0] RESET_CAUSE_REG_RST = 32'h00000001;
    localparam logic [31:0] RESET_CAUSE_REG_MASK = 32'h00010001;
    localparam logic [31:0] GATE_MASK = 32'h000000FF;
    localparam int GATE_W = 8;
    // ************************************************************
    // Selection codes and timing
    // ************************************************************
    localparam logic [2:0] OSC_SEL_MAIN_OSCILLATOR = 3'h0;
    localparam logic [2:0] OSC_SEL_INTERNAL_FAST_OSCILLATOR = 3'h1;
    localparam logic [2:0] OSC_SEL_IOSC4 = 3'h2;
    localparam logic [2:0] OSC_SEL_LF = 3'h3;
    localparam logic [2:0] OSC_SEL_RTC = 3'h7;
    localparam logic [5:0] PLL_MIN_DIV_ENC = 6'h03;
    localparam int VCO_MHZ = 400;
    localparam int ADC_MHZ = 16;
    localparam logic [5:0] ADC_DIV_ENC = 6'(VCO_MHZ / ADC_MHZ - 1);
    localparam int REF_PERIOD_NS = 100;
    localparam int MAIN_OSCILLATOR_TIMEOUT_NS = 2000;
    localparam logic [7:0] MAIN_OSCILLATOR_TIMEOUT_CYC =
        8'((MAIN_OSCILLATOR_TIMEOUT_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
    localparam logic [5:0] POR_INTERNAL_FAST_OSCILLATOR_PERIODS = 6'h20;
    typedef enum logic [2:0] {
        SRC_MAIN_OSCILLATOR = 3'h0,
        SRC_INTERNAL_FAST_OSCILLATOR = 3'h1,
        SRC_IOSC4 = 3'h2,
        SRC_LF = 3'h3,
        SRC_PLL = 3'h4,
        SRC_RTC = 3'h7
    } scd_src_t;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HOLD = 2'b01,
        ST_REL = 2'b11
    } scd_state_t;
    function automatic logic [31:0] applySel(input logic [31:0] oldV,
                                             input logic [31:0] newV,
                                             input logic [3:0] sel);
        logic [31:0] res;
        res = oldV;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = newV[i*8 +: 8];
            end
        end
        return res;
    endfunction
endpackage

// File: core/scd_div_if.sv
`timescale 1ns/10ps
`default_nettype none
interface scd_div_if;
    logic tickIn;
    logic [5:0] divEnc;
    logic tickOut;
    modport ctl(output tickIn, output divEnc, input tickOut);
    modport div(input tickIn, input divEnc, output tickOut);
endinterface
`default_nettype wire

// File: core/scd_clk_div.sv
`timescale 1ns/10ps
`default_nettype none
module scd_clk_div
    import scd_pkg::*;
(
    input wire logic ref_clk, // Block clock
    input wire logic rstn, // Async reset, active low
    scd_div_if.div dv // Tick in, ratio, tick out
);
    logic [5:0] cnt_q;
    logic [5:0] div_q;
    logic tick_q;
    wire terminal = (cnt_q >= div_q);
    // ************************************************************
    // Counter
    // ************************************************************
    // Ratio is reloaded only at the period boundary, so no short period
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 6'h00;
            div_q <= 6'h00;
            tick_q <= 1'b0;
        end else begin
            tick_q <= dv.tickIn && terminal;
            if (dv.tickIn) begin
                cnt_q <= terminal ? 6'h00 : cnt_q + 6'h01;
                if (terminal) begin
                    div_q <= dv.divEnc;
                end
            end
        end
    end
    assign dv.tickOut = tick_q;
    property p_out_needs_in;
        @(posedge ref_clk) disable iff (!rstn) dv.tickOut |-> $past(dv.tickIn);
    endproperty
    a_out_needs_in: assert property (p_out_needs_in) else $error("tick without input");
endmodule
`default_nettype wire

// File: core/scd_top.sv
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module scd_top
    import scd_pkg::*;
(
    input wire logic ref_clk, // 10 MHz block clock
    input wire logic rstn, // Power-on reset, async, active low
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic [7:0] wb_adr_i, // Wishbone byte address
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic ioscTick, // Internal fast oscillator edge
    input wire logic moscTick, // Main oscillator edge
    input wire logic lfoscTick, // Internal slow oscillator edge
    input wire logic rtcTick, // Real-time oscillator edge
    input wire logic pllTick, // PLL VCO edge
    input wire logic nmiPin, // Interrupt pin, asynchronous
    input wire logic nmiPinEnable, // Pin alternate function enabled
    output logic sysClkTick, // System clock enable
    output logic pwmClkTick, // Pulse modulator clock enable
    output logic adcClkTick, // Converter clock enable
    output logic [GATE_W-1:0] periphClkTick, // Gated peripheral clocks
    output logic nmiReq, // Non-maskable interrupt request
    output logic coreRstN, // Internal reset, active low
    output logic moscEnable, // Main oscillator power
    output logic ioscEnable, // Internal oscillator power
    output logic pllPowerDown // PLL power down
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // ************************************************************
    // Registers and bus
    // ************************************************************
    logic [31:0] run_clock_config_reg_q;
    logic [31:0] run_clock_config_ext_reg_q;
    logic [31:0] main_osc_control_reg_q;
    logic [31:0] reset_cause_reg_q;
    logic [31:0] clkGate_q;
    logic [31:0] datOut_q;
    logic ack_q;
    scd_state_t state_q;
    scd_state_t state_d;
    scd_src_t actSrc_q;
    scd_src_t wantSrc;
    scd_src_t oscillator_select_field;

    wire [7:0] wordAdr = {wb_adr_i[7:2], 2'b00};
    wire access = wb_cyc_i && wb_stb_i && !ack_q;
    wire wrAny = access && wb_we_i && (state_q == ST_RUN);
    wire wrRun = wrAny && (wordAdr == OFF_RUN_CFG);
    wire wrExt = wrAny && (wordAdr == OFF_RUN_CFG_EXT);
    wire wrMosc = wrAny && (wordAdr == OFF_MAIN_OSCILLATOR_CTL);
    wire wrResc = wrAny && (wordAdr == OFF_RESET_CAUSE);
    wire wrGate = wrAny && (wordAdr == OFF_CLK_GATE);
    wire inPor = (state_q == ST_HOLD);

    // ************************************************************
    // Interrupt pin synchroniser
    // ************************************************************
    logic [2:0] nmiSync_q;
    logic nmiLevel_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            nmiSync_q <= 3'h0;
            nmiLevel_q <= 1'b0;
        end else begin
            nmiSync_q <= {nmiSync_q[1:0], nmiPin};
            if (nmiSync_q[1] == nmiSync_q[2]) begin
                nmiLevel_q <= nmiSync_q[2];
            end
        end
    end
    wire pinNmi = nmiLevel_q && nmiPinEnable;

    // ************************************************************
    // Effective configuration
    // ************************************************************
    wire useExt = run_clock_config_ext_reg_q[F_X_USE];
    wire effSkip = useExt ? run_clock_config_ext_reg_q[F_X_SKIP] : run_clock_config_reg_q[F_SKIP];
    wire effPllPd = useExt ? run_clock_config_ext_reg_q[F_X_PLL_PD] :
        run_clock_config_reg_q[F_PLL_PD];
    wire [2:0] effOsc = useExt ? run_clock_config_ext_reg_q[F_X_OSC_SEL +: 3] :
        {1'b0, run_clock_config_reg_q[F_OSC_SEL +: 2]};
    wire [5:0] effDiv = useExt ? run_clock_config_ext_reg_q[F_X_DIV +: 6] :
        {2'b00, run_clock_config_reg_q[F_DIV +: 4]};
    wire usePll = !effSkip && (effOsc == OSC_SEL_MAIN_OSCILLATOR) && !effPllPd;
    // Base divider bypass only applies off the PLL path
    wire divBypass = !useExt && !run_clock_config_reg_q[F_USE_DIV] && !usePll;
    // Reserved PLL ratios are clamped to the fastest legal one
    wire [5:0] sysDivEnc = divBypass ? 6'h00 :
        (usePll && (effDiv < PLL_MIN_DIV_ENC)) ? PLL_MIN_DIV_ENC : effDiv;

    // ************************************************************
    // Source selection
    // ************************************************************
    always_comb begin
        unique case (effOsc)
            OSC_SEL_MAIN_OSCILLATOR: oscillator_select_field = SRC_MAIN_OSCILLATOR;
            OSC_SEL_INTERNAL_FAST_OSCILLATOR: oscillator_select_field = SRC_INTERNAL_FAST_OSCILLATOR;
            OSC_SEL_IOSC4: oscillator_select_field = SRC_IOSC4;
            OSC_SEL_LF: oscillator_select_field = SRC_LF;
            OSC_SEL_RTC: oscillator_select_field = SRC_RTC;
            default: oscillator_select_field = SRC_INTERNAL_FAST_OSCILLATOR;
        endcase
        wantSrc = usePll ? SRC_PLL : oscillator_select_field;
    end

    logic pllHalf_q;
    logic [1:0] ioscQuarter_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pllHalf_q <= 1'b0;
            ioscQuarter_q <= 2'h0;
        end else begin
            if (pllTick) begin
                pllHalf_q <= !pllHalf_q;
            end
            if (ioscTick) begin
                ioscQuarter_q <= ioscQuarter_q + 2'h1;
            end
        end
    end
    wire pllHalfTick = pllTick && pllHalf_q;
    wire ioscQuarterTick = ioscTick && (ioscQuarter_q == 2'h3);
    wire srcTick = (actSrc_q == SRC_PLL) ? pllHalfTick :
        (actSrc_q == SRC_MAIN_OSCILLATOR) ? moscTick :
        (actSrc_q == SRC_IOSC4) ? ioscQuarterTick :
        (actSrc_q == SRC_LF) ? lfoscTick :
        (actSrc_q == SRC_RTC) ? rtcTick : ioscTick;

    // Source swaps at a system clock boundary, or at once during internal reset; outside reset a dead old source blocks it
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            actSrc_q <= SRC_INTERNAL_FAST_OSCILLATOR;
        end else if (inPor || sysClkTick) begin
            actSrc_q <= wantSrc;
        end
    end

    // ************************************************************
    // Dividers
    // ************************************************************
    scd_div_if sysIf();
    scd_div_if pwmIf();
    scd_div_if adcIf();

    function automatic logic [5:0] pwmRatio(input logic [2:0] code);
        logic [6:0] full;
        full = (7'h02 << code) - 7'h01;
        return (code > 3'h5) ? 6'h3F : full[5:0];
    endfunction

    assign sysIf.tickIn = srcTick;
    assign sysIf.divEnc = sysDivEnc;
    assign pwmIf.tickIn = sysIf.tickOut;
    assign pwmIf.divEnc = run_clock_config_reg_q[F_PWM_USE] ?
        pwmRatio(run_clock_config_reg_q[F_PWM_DIV +: 3]) : 6'h00;
    assign adcIf.tickIn = pllTick;
    assign adcIf.divEnc = ADC_DIV_ENC;

    scd_clk_div uSysDiv (.ref_clk(ref_clk), .rstn(rstn), .dv(sysIf.div));
    scd_clk_div uPwmDiv (.ref_clk(ref_clk), .rstn(rstn), .dv(pwmIf.div));
    scd_clk_div uAdcDiv (.ref_clk(ref_clk), .rstn(rstn), .dv(adcIf.div));

    assign sysClkTick = sysIf.tickOut;
    assign pwmClkTick = pwmIf.tickOut;
    assign adcClkTick = adcIf.tickOut && !effPllPd;
    assign periphClkTick = {GATE_W{sysClkTick}} & clkGate_q[GATE_W-1:0];

    // ************************************************************
    // Main oscillator check and internal reset
    // ************************************************************
    logic [7:0] moscSilent_q;
    logic [5:0] porCnt_q;
    wire checkEn = main_osc_control_reg_q[F_CHECK_EN];
    wire failDetect = checkEn && (state_q == ST_RUN) && !moscTick &&
        (moscSilent_q >= MAIN_OSCILLATOR_TIMEOUT_CYC - 8'h01);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            moscSilent_q <= 8'h00;
        end else if (!checkEn || moscTick || inPor) begin
            moscSilent_q <= 8'h00;
        end else if (moscSilent_q != 8'hFF) begin
            moscSilent_q <= moscSilent_q + 8'h01;
        end
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: if (failDetect) state_d = ST_HOLD;
            ST_HOLD: if (ioscTick && (porCnt_q == POR_INTERNAL_FAST_OSCILLATOR_PERIODS - 6'h01)) state_d = ST_REL;
            ST_REL: state_d = ST_RUN;
            default: state_d = ST_RUN;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_RUN;
            porCnt_q <= 6'h00;
            coreRstN <= 1'b1;
            nmiReq <= 1'b0;
        end else begin
            state_q <= state_d;
            porCnt_q <= !inPor ? 6'h00 : ioscTick ? porCnt_q + 6'h01 : porCnt_q;
            coreRstN <= (state_d != ST_HOLD);
            nmiReq <= pinNmi || (state_d == ST_REL);
        end
    end

    // ************************************************************
    // Register file
    // ************************************************************
    // Internal reset returns the clock setup to its power-on form,
    // which puts the system clock back on the internal oscillator
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            run_clock_config_reg_q <= RUN_CFG_RST;
            run_clock_config_ext_reg_q <= EXT_CFG_RST;
            main_osc_control_reg_q <= 32'h00000000;
            clkGate_q <= 32'h00000000;
        end else if (inPor) begin
            run_clock_config_reg_q <= RUN_CFG_RST;
            run_clock_config_ext_reg_q <= EXT_CFG_RST;
            main_osc_control_reg_q <= 32'h00000000;
            clkGate_q <= 32'h00000000;
        end else begin
            if (wrRun) begin
                run_clock_config_reg_q <= applySel(run_clock_config_reg_q, wb_dat_i, wb_sel_i)
                    & RUN_CFG_MASK;
            end
            if (wrExt) begin
                run_clock_config_ext_reg_q <=
                    applySel(run_clock_config_ext_reg_q, wb_dat_i, wb_sel_i) & EXT_CFG_MASK;
            end
            if (wrMosc) begin
                main_osc_control_reg_q <= applySel(main_osc_control_reg_q, wb_dat_i, wb_sel_i)
                    & MAIN_OSCILLATOR_CTL_MASK;
            end
            if (wrGate) begin
                clkGate_q <= applySel(clkGate_q, wb_dat_i, wb_sel_i) & GATE_MASK;
            end
        end
    end

    // Cause bits are sticky; writing zero clears, a new failure wins
    wire [31:0] rescWr = wrResc ?
        (applySel(reset_cause_reg_q, wb_dat_i, wb_sel_i) & RESET_CAUSE_REG_MASK) : reset_cause_reg_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reset_cause_reg_q <= RESET_CAUSE_REG_RST;
        end else begin
            reset_cause_reg_q <= rescWr | (32'(failDetect) << F_FAIL_FLAG);
        end
    end

    wire [31:0] statusWord = {24'h000000, 1'b0, actSrc_q, state_q, pinNmi, nmiLevel_q};
    wire [31:0] readMux = (wordAdr == OFF_RUN_CFG) ? run_clock_config_reg_q :
        (wordAdr == OFF_RUN_CFG_EXT) ? run_clock_config_ext_reg_q :
        (wordAdr == OFF_MAIN_OSCILLATOR_CTL) ? main_osc_control_reg_q :
        (wordAdr == OFF_RESET_CAUSE) ? reset_cause_reg_q :
        (wordAdr == OFF_CLK_GATE) ? clkGate_q :
        (wordAdr == OFF_STATUS) ? statusWord : 32'h00000000;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            datOut_q <= 32'h00000000;
        end else begin
            ack_q <= access;
            if (access && !wb_we_i) begin
                datOut_q <= readMux;
            end
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = datOut_q;
    assign moscEnable = !run_clock_config_reg_q[F_MAIN_OSCILLATOR_DIS];
    assign ioscEnable = !run_clock_config_reg_q[F_INTERNAL_FAST_OSCILLATOR_DIS] || (state_q != ST_RUN);
    assign pllPowerDown = effPllPd;

    // ************************************************************
    // Checks
    // ************************************************************
    logic [5:0] holdTicks_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            holdTicks_q <= 6'h00;
        end else if (state_q == ST_RUN) begin
            holdTicks_q <= 6'h00;
        end else if (inPor && ioscTick) begin
            holdTicks_q <= holdTicks_q + 6'h01;
        end
    end

    property p_pin_nmi;
        pinNmi |=> nmiReq;
    endproperty
    a_pin_nmi: assert property (p_pin_nmi) else $error("pin did not raise nmi");
    property p_fail_nmi;
        (state_q == ST_REL) |-> nmiReq && coreRstN && $past(!coreRstN);
    endproperty
    a_fail_nmi: assert property (p_fail_nmi) else $error("no nmi after reset");
    property p_fail_flag;
        failDetect |=> reset_cause_reg_q[F_FAIL_FLAG] && !coreRstN;
    endproperty
    a_fail_flag: assert property (p_fail_flag) else $error("fail flag not set");
    property p_check_off;
        !checkEn |-> !failDetect;
    endproperty
    a_check_off: assert property (p_check_off) else $error("check fired disabled");
    property p_hold_rst;
        (state_q == ST_HOLD) |-> !coreRstN && ioscEnable;
    endproperty
    a_hold_rst: assert property (p_hold_rst) else $error("reset not held");
    property p_por_len;
        (state_q == ST_REL) |-> (holdTicks_q == POR_INTERNAL_FAST_OSCILLATOR_PERIODS) && (actSrc_q == SRC_INTERNAL_FAST_OSCILLATOR);
    endproperty
    a_por_len: assert property (p_por_len) else $error("bad reset length");
    property p_pll_min;
        usePll |-> (sysDivEnc >= PLL_MIN_DIV_ENC) && (wantSrc == SRC_PLL);
    endproperty
    a_pll_min: assert property (p_pll_min) else $error("reserved pll ratio");
    property p_ext_wins;
        useExt |-> (sysDivEnc == effDiv) || usePll;
    endproperty
    a_ext_wins: assert property (p_ext_wins) else $error("ext divider ignored");
    property p_gate;
        clkGate_q[0] && sysClkTick |-> periphClkTick[0];
    endproperty
    a_gate: assert property (p_gate) else $error("gate blocked clock");
endmodule
`default_nettype wire

// File: tb/scd_osc_model.sv
`timescale 1ns/10ps
`default_nettype none
// ***
// Oscillator edge model
// ***
module scd_osc_model (
    input wire logic ref_clk, // Block clock
    input wire logic moscRun, // Crystal alive
    input wire logic moscEn, // Main oscillator power
    input wire logic ioscEn, // Internal oscillator power
    input wire logic pllPd, // PLL power down
    output logic [4:0] tick // PLL, RTC, slow, main, internal
);
    int n = 0;
    // Unpowered sources give no edges, so a missed enable stalls the clock
    always @(posedge ref_clk) begin
        n <= n + 1;
        tick[0] <= ioscEn && n % 2 == 0;
        tick[1] <= moscEn && moscRun && n % 3 == 0;
        tick[2] <= n % 7 == 0;
        tick[3] <= n % 11 == 0;
        tick[4] <= !pllPd;
    end
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
    import scd_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic nmiPin = 1'b0;
    logic nmiEn = 1'b0;
    logic moscRun = 1'b1;
    logic [31:0] rdat;
    logic ack, sysT, pwmT, adcT, nmiReq, coreRstN, moscEn, ioscEn, pllPd;
    logic [7:0] gateT;
    logic [4:0] tk;
    logic [15:0] lf = 16'h0058;
    int err_count = 0;
    int compares = 0;
    wire logic [2:0] tk3 = {adcT, pwmT, sysT};
    always #50 ref_clk = ~ref_clk;
    scd_top DUT (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_sel_i(4'hF), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ioscTick(tk[0]), .moscTick(tk[1]), .lfoscTick(tk[2]), .rtcTick(tk[3]), .pllTick(tk[4]),
        .nmiPin(nmiPin), .nmiPinEnable(nmiEn), .sysClkTick(sysT), .pwmClkTick(pwmT),
        .adcClkTick(adcT), .periphClkTick(gateT), .nmiReq(nmiReq), .coreRstN(coreRstN),
        .moscEnable(moscEn), .ioscEnable(ioscEn), .pllPowerDown(pllPd));
    scd_osc_model osc (.ref_clk(ref_clk), .moscRun(moscRun), .moscEn(moscEn), .ioscEn(ioscEn),
        .pllPd(pllPd), .tick(tk));
    // ***
    // Helpers
    // ***
    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // PLL stays powered so leaving it never waits on a dead source
    function automatic logic [31:0] cfg(input logic [1:0] s, input logic sk,
                                        input logic [3:0] d, input logic [2:0] pw);
        logic [31:0] v;
        v = 32'h0;
        v[F_OSC_SEL +: 2] = s;
        v[F_SKIP] = sk;
        v[F_USE_DIV] = 1'b1;
        v[F_DIV +: 4] = d;
        v[F_PWM_USE] = 1'b1;
        v[F_PWM_DIV +: 3] = pw;
        return v;
    endfunction
    function automatic int expSys(input logic [1:0] s, input logic sk, input logic [3:0] d);
        if (!sk && s == 2'h0) return 2 * ((d < 4'h3) ? 4 : d + 1);
        return (s == 2'h0 ? 3 : s == 2'h1 ? 2 : s == 2'h2 ? 8 : 7) * (d + 1);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic hang();
        chk(32'h0, 32'h1);
        print_verdict();
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int k;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (k = 0; k < 20 && ack !== 1'b1; k++) @(posedge ref_clk);
        if (k == 20) hang();
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Last of four intervals, so a pending source switch has settled
    task automatic meas(input int w, output int p);
        int k;
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            for (k = 1; k < 3000 && tk3[w] !== 1'b1; k++) @(posedge ref_clk);
            if (k == 3000) hang();
            p = k;
        end
    endtask
    // ***
    // Main sequence
    // ***
    initial begin
        int p, k;
        logic [31:0] r;
        logic [3:0] d;
        logic [1:0] s;
        logic [5:0] d6;
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        wb(1'b0, OFF_RUN_CFG, 32'h0, r);
        chk(r, RUN_CFG_RST);
        wb(1'b0, OFF_RUN_CFG_EXT, 32'h0, r);
        chk(r, EXT_CFG_RST);
        wb(1'b0, 8'h18, 32'h0, r);
        chk(r, 32'h0);
        meas(0, p);
        chk(p, 2);
        lf = nxt(lf);
        wb(1'b1, OFF_CLK_GATE, {24'h0, lf[7:0] | 8'h01}, r);
        repeat (16) begin
            @(posedge ref_clk);
            chk(gateT, {8{sysT}} & (lf[7:0] | 8'h01));
        end
        for (int i = 0; i < 6; i++) begin
            lf = nxt(lf);
            s = (i < 4) ? 2'(i) : 2'h0;
            d = (i == 5) ? 4'h1 : lf[3:0];
            wb(1'b1, OFF_RUN_CFG, cfg(s, i < 4, d, 3'h0), r);
            meas(0, p);
            chk(p, expSys(s, i < 4, d));
            meas(2, p);
            chk(p, 25);
        end
        lf = nxt(lf);
        wb(1'b1, OFF_RUN_CFG, cfg(2'h1, 1'b1, 4'h0, lf[2:0]), r);
        meas(1, p);
        chk(p, 2 << ((lf[2:0] > 3'h5) ? 6 : lf[2:0] + 1));
        d6 = lf[8:3] | 6'h20;
        wb(1'b1, OFF_RUN_CFG_EXT, 32'h80000870 | {3'h0, d6, 23'h0}, r);
        meas(0, p);
        chk(p, 11 * (d6 + 1));
        wb(1'b1, OFF_RUN_CFG_EXT, EXT_CFG_RST, r);
        nmiPin <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk(nmiReq, 1'b0);
        nmiEn <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk(nmiReq, 1'b1);
        wb(1'b0, OFF_STATUS, 32'h0, r);
        chk(r & 32'h0000000F, 32'h00000003);
        nmiPin <= 1'b0;
        // Three sync stages, agreement and the request flop take five edges
        repeat (8) @(posedge ref_clk);
        chk(nmiReq, 1'b0);
        // Internal oscillator off, so the failure path must power it again
        wb(1'b1, OFF_RUN_CFG, cfg(2'h0, 1'b1, 4'h0, 3'h0) | 32'h2, r);
        moscRun <= 1'b0;
        repeat (40) @(posedge ref_clk);
        chk(coreRstN, 1'b1);
        wb(1'b1, OFF_MAIN_OSCILLATOR_CTL, 32'h1, r);
        for (k = 0; k < 40 && coreRstN !== 1'b0; k++) @(posedge ref_clk);
        if (k == 40) hang();
        chk(ioscEn, 1'b1);
        for (k = 0; k < 200 && coreRstN !== 1'b1; k++) @(posedge ref_clk);
        if (k == 200) hang();
        chk(nmiReq, 1'b1);
        // Oscillator edge phase adds at most one cycle
        chk(k / 2, 32);
        wb(1'b0, OFF_RESET_CAUSE, 32'h0, r);
        chk(r, 32'h00010001);
        meas(0, p);
        chk(p, 2);
        print_verdict();
    end
endmodule
`default_nettype wire
